// ===== rtl/dspmac_pkg.sv
`default_nettype none
package dspmac_pkg;
   // ----------------------------------------------------------------
   // arithmetic functions of one half
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DSPMAC_SIMPLE = 2'b00,
      DSPMAC_ACCUM = 2'b01,
      DSPMAC_ADD2 = 2'b10,
      DSPMAC_ADD4 = 2'b11
   } dspmac_func_t;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam int CTRL_FUNC_LSB = 0;
   localparam int CTRL_NARROW = 2;
   localparam int CTRL_HALF_STRIDE = 4;
   localparam int CTRL_WIDE = 8;
   localparam int CTRL_SET_LSB = 10;
   localparam int CTRL_SET_STRIDE = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_2000;
   localparam logic [31:0] CTRL_MASK = 32'h0000_3D77;
   localparam int STAT_CLAMP_LSB = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ----------------------------------------------------------------
   // widths and fixed-point constants
   // ----------------------------------------------------------------
   localparam int W_NARROW = 9;
   localparam int W_NORMAL = 18;
   localparam int W_WIDE = 36;
   localparam logic [36:0] Q_RND_HALF = 37'h00_0000_4000;
   localparam logic [36:0] Q_FRAC_MASK = 37'h00_0000_7FFF;
   localparam logic [36:0] Q_POS_MAX = 37'h00_3FFF_FFFF;
   localparam logic [36:0] Q_NEG_MAX = 37'h1F_C000_0000;
   localparam logic [51:0] ACC_POS_MAX = 52'h7_FFFF_FFFF_FFFF;
   localparam logic [51:0] ACC_NEG_MAX = 52'h8_0000_0000_0000;
   localparam logic [51:0] ACC_RND_HALF = 52'h0_0000_0000_4000;
   localparam logic [51:0] ACC_FRAC_MASK = 52'h0_0000_0000_7FFF;
endpackage
`default_nettype wire

// ===== rtl/dspmac_block.sv
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module dspmac_block (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [17:0] operandA [4],
   input wire logic [17:0] operandB [4],
   input wire logic [3:0] opASrcSel,
   input wire logic [3:0] opBSrcSel,
   input wire logic [17:0] chainAIn,
   input wire logic [17:0] chainBIn,
   output logic [17:0] chainAOut,
   output logic [17:0] chainBOut,
   input wire logic [3:0] clockEnableSet,
   input wire logic [3:0] asyncClearSet,
   input wire logic signASel,
   input wire logic signBSel,
   input wire logic lowerAddOrSubtract,
   input wire logic upperAddOrSubtract,
   input wire logic lowerPairRndSel,
   input wire logic upperPairRndSel,
   input wire logic lowerPairClampSel,
   input wire logic upperPairClampSel,
   input wire logic lowerSumRndSel,
   input wire logic upperSumRndSel,
   input wire logic lowerAccClampSel,
   input wire logic upperAccClampSel,
   input wire logic lowerAccLoad,
   input wire logic upperAccLoad,
   output logic [17:0] resultOut [8],
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // one multiplier serves every size; w picks the operand sign bit
   function automatic logic [73:0] mulS(input logic [35:0] a, input logic [35:0] b,
         input logic sa, input logic sb, input int w);
      logic [36:0] m;
      logic signed [36:0] ea;
      logic signed [36:0] eb;
      logic signed [73:0] p;
      m = ~((37'h1 << w) - 37'h1);
      ea = signed'((sa & a[w-1]) ? ({1'b0, a} | m) : {1'b0, a});
      eb = signed'((sb & b[w-1]) ? ({1'b0, b} | m) : {1'b0, b});
      p = 74'(ea) * 74'(eb);
      return p;
   endfunction

   function automatic logic qOver(input logic [36:0] v);
      return v[36:30] != {7{v[36]}};
   endfunction

   // round to Q1.15 then clamp; rounding may itself push into overflow
   function automatic logic [36:0] qFix(input logic [36:0] p, input logic rnd,
         input logic sat);
      logic [36:0] v;
      v = rnd ? ((p + dspmac_pkg::Q_RND_HALF) & ~dspmac_pkg::Q_FRAC_MASK) : p;
      if (sat && qOver(v)) begin
         v = v[36] ? dspmac_pkg::Q_NEG_MAX : dspmac_pkg::Q_POS_MAX;
      end
      return v;
   endfunction

   function automatic logic regKnown(input logic [3:0] addr);
      return addr == dspmac_pkg::ADDR_CTRL || addr == dspmac_pkg::ADDR_STATUS;
   endfunction

   // ----------------------------------------------------------------
   // configuration and per-half control
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [1:0] clampHit_q;
   logic wideSel;
   logic [1:0] halfEn;
   logic [1:0] halfClr;
   logic [1:0] addSub;
   logic [1:0] pairRnd;
   logic [1:0] pairClamp;
   logic [1:0] sumRnd;
   logic [1:0] accClamp;
   logic [1:0] accLoad;
   dspmac_pkg::dspmac_func_t funcSel [2];
   logic [1:0] narrowSel;
   logic [1:0] halfSet [2];

   assign wideSel = ctrl_q[dspmac_pkg::CTRL_WIDE];
   assign addSub = {upperAddOrSubtract, lowerAddOrSubtract};
   assign pairRnd = {upperPairRndSel, lowerPairRndSel};
   assign pairClamp = {upperPairClampSel, lowerPairClampSel};
   assign sumRnd = {upperSumRndSel, lowerSumRndSel};
   assign accClamp = {upperAccClampSel, lowerAccClampSel};
   assign accLoad = {upperAccLoad, lowerAccLoad};

   // ----------------------------------------------------------------
   // operand registers and multipliers, one unit per row
   // ----------------------------------------------------------------
   logic [17:0] opA_q [4];
   logic [17:0] opB_q [4];
   logic [17:0] prevA [4];
   logic [17:0] prevB [4];
   logic [36:0] p18 [4];
   logic [36:0] pQ [4];
   logic [18:0] pLo [4];
   logic [18:0] pHi [4];
   logic [3:0] pairHit;
   logic [73:0] p72;

   assign prevA[0] = chainAIn;
   assign prevB[0] = chainBIn;
   assign chainAOut = opA_q[3];
   assign chainBOut = opB_q[3];

   genvar r;
   generate
      for (r = 0; r < 4; r++) begin : gRow
         logic [73:0] full;
         logic [73:0] lo;
         logic [73:0] hi;
         if (r > 0) begin : gLink
            assign prevA[r] = opA_q[r-1];
            assign prevB[r] = opB_q[r-1];
         end
         always_ff @(posedge clk_sys) begin
            if (rst || halfClr[r/2]) begin
               opA_q[r] <= 18'h0;
               opB_q[r] <= 18'h0;
            end else if (halfEn[r/2]) begin
               opA_q[r] <= opASrcSel[r] ? prevA[r] : operandA[r];
               opB_q[r] <= opBSrcSel[r] ? prevB[r] : operandB[r];
            end
         end
         assign full = mulS({18'h0, opA_q[r]}, {18'h0, opB_q[r]}, signASel, signBSel,
            dspmac_pkg::W_NORMAL);
         assign lo = mulS({27'h0, opA_q[r][8:0]}, {27'h0, opB_q[r][8:0]}, signASel,
            signBSel, dspmac_pkg::W_NARROW);
         assign hi = mulS({27'h0, opA_q[r][17:9]}, {27'h0, opB_q[r][17:9]}, signASel,
            signBSel, dspmac_pkg::W_NARROW);
         assign p18[r] = full[36:0];
         assign pLo[r] = lo[18:0];
         assign pHi[r] = hi[18:0];
         assign pQ[r] = qFix(p18[r], pairRnd[r/2], pairClamp[r/2]);
         assign pairHit[r] = pairClamp[r/2] && qOver(pairRnd[r/2] ?
            ((p18[r] + dspmac_pkg::Q_RND_HALF) & ~dspmac_pkg::Q_FRAC_MASK) : p18[r]);
      end
   endgenerate

   // whole block as one 36-bit multiplier over rows 0 and 1
   assign p72 = mulS({opA_q[1], opA_q[0]}, {opB_q[1], opB_q[0]}, signASel, signBSel,
      dspmac_pkg::W_WIDE);

   // ----------------------------------------------------------------
   // adders, accumulators and result registers, one set per half
   // ----------------------------------------------------------------
   logic [37:0] sum18 [2];
   logic [38:0] sum18Quad;
   logic [51:0] acc_q [2];
   logic [17:0] result_q [8];
   logic [71:0] halfOut [2];

   assign sum18Quad = 39'(signed'(sum18[0])) + 39'(signed'(sum18[1]));
   assign resultOut = result_q;

   genvar h;
   generate
      for (h = 0; h < 2; h++) begin : gHalf
         localparam int R0 = 2 * h;
         localparam int R1 = 2 * h + 1;
         logic [19:0] s9 [2];
         logic [20:0] s9Quad;
         logic [52:0] accP;
         logic [52:0] accSum;
         logic accOvf;
         logic [51:0] accNext;
         logic [51:0] accView;
         logic [71:0] wideOut;

         assign funcSel[h] = dspmac_pkg::dspmac_func_t'(ctrl_q[dspmac_pkg::CTRL_FUNC_LSB +
            h * dspmac_pkg::CTRL_HALF_STRIDE +: 2]);
         assign narrowSel[h] = ctrl_q[dspmac_pkg::CTRL_NARROW +
            h * dspmac_pkg::CTRL_HALF_STRIDE];
         assign halfSet[h] = ctrl_q[dspmac_pkg::CTRL_SET_LSB +
            h * dspmac_pkg::CTRL_SET_STRIDE +: 2];
         // clear ignores every enable, as an asynchronous clear would
         assign halfEn[h] = ce & clockEnableSet[halfSet[h]];
         assign halfClr[h] = asyncClearSet[halfSet[h]];

         assign sum18[h] = addSub[h] ? 38'(signed'(pQ[R0])) + 38'(signed'(pQ[R1]))
            : 38'(signed'(pQ[R0])) - 38'(signed'(pQ[R1]));
         assign s9[0] = addSub[h] ? 20'(signed'(pLo[R0])) + 20'(signed'(pHi[R0]))
            : 20'(signed'(pLo[R0])) - 20'(signed'(pHi[R0]));
         assign s9[1] = addSub[h] ? 20'(signed'(pLo[R1])) + 20'(signed'(pHi[R1]))
            : 20'(signed'(pLo[R1])) - 20'(signed'(pHi[R1]));
         assign s9Quad = 21'(signed'(s9[0])) + 21'(signed'(s9[1]));

         // 18-bit only: a narrow setting is ignored in accumulate mode
         assign accP = 53'(signed'(p18[R0]));
         assign accSum = accLoad[h] ? (addSub[h] ? accP : 53'h0 - accP)
            : (addSub[h] ? 53'(signed'(acc_q[h])) + accP : 53'(signed'(acc_q[h])) - accP);
         assign accOvf = accSum[52] != accSum[51];
         assign accNext = (accClamp[h] && accOvf) ? (accSum[52] ? dspmac_pkg::ACC_NEG_MAX
            : dspmac_pkg::ACC_POS_MAX) : accSum[51:0];
         assign accView = sumRnd[h] ? ((acc_q[h] + dspmac_pkg::ACC_RND_HALF) &
            ~dspmac_pkg::ACC_FRAC_MASK) : acc_q[h];

         // wide products land on the lower half; the upper half reads zero
         assign wideOut = (h == 0) ? p72[71:0] : 72'h0;
         // the 18-bit four-product sum needs all four rows, so only the lower half has it
         assign halfOut[h] = wideSel ? wideOut :
            (funcSel[h] == dspmac_pkg::DSPMAC_SIMPLE) ? (narrowSel[h] ?
               {pHi[R1][17:0], pLo[R1][17:0], pHi[R0][17:0], pLo[R0][17:0]}
               : {pQ[R1][35:0], pQ[R0][35:0]}) :
            (funcSel[h] == dspmac_pkg::DSPMAC_ACCUM) ? 72'(signed'(accView)) :
            (funcSel[h] == dspmac_pkg::DSPMAC_ADD2) ? (narrowSel[h] ?
               {36'(signed'(s9[1])), 36'(signed'(s9[0]))} : 72'(signed'(sum18[h]))) :
            narrowSel[h] ? 72'(signed'(s9Quad)) :
            ((h == 0) ? 72'(signed'(sum18Quad)) : 72'h0);

         always_ff @(posedge clk_sys) begin
            if (rst || halfClr[h]) begin
               acc_q[h] <= 52'h0;
               {result_q[4*h+3], result_q[4*h+2], result_q[4*h+1], result_q[4*h]} <= 72'h0;
               clampHit_q[h] <= 1'b0;
            end else if (halfEn[h]) begin
               if (!wideSel && funcSel[h] == dspmac_pkg::DSPMAC_ACCUM) begin
                  acc_q[h] <= accNext;
               end
               {result_q[4*h+3], result_q[4*h+2], result_q[4*h+1], result_q[4*h]}
                  <= halfOut[h];
               clampHit_q[h] <= pairHit[R0] | pairHit[R1] | (accClamp[h] & accOvf);
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // register bus slave
   // ----------------------------------------------------------------
   logic awready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic wrGo;
   logic wrTake;
   logic rdGo;
   logic rdTake;
   logic [31:0] strbMask;
   logic [31:0] ctrl_d;
   logic [31:0] rdValue;

   // accept both write channels together, one request at a time
   assign wrGo = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
   assign wrTake = awready_q & s_axi_awvalid & s_axi_wvalid;
   assign rdGo = s_axi_arvalid & ~arready_q & ~rvalid_q;
   assign rdTake = arready_q & s_axi_arvalid;
   assign strbMask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
      {8{s_axi_wstrb[0]}}};
   assign ctrl_d = ((ctrl_q & ~strbMask) | (s_axi_wdata & strbMask)) &
      dspmac_pkg::CTRL_MASK;
   assign rdValue = (s_axi_araddr == dspmac_pkg::ADDR_CTRL) ? ctrl_q :
      (s_axi_araddr == dspmac_pkg::ADDR_STATUS) ?
      (32'(clampHit_q) << dspmac_pkg::STAT_CLAMP_LSB) : 32'h0;

   assign s_axi_awready = awready_q;
   assign s_axi_wready = awready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_q <= dspmac_pkg::CTRL_RESET;
         awready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= dspmac_pkg::RESP_OKAY;
      end else if (ce) begin
         awready_q <= wrGo;
         if (wrTake) begin
            bvalid_q <= 1'b1;
            bresp_q <= regKnown(s_axi_awaddr) ? dspmac_pkg::RESP_OKAY
               : dspmac_pkg::RESP_DECERR;
            if (s_axi_awaddr == dspmac_pkg::ADDR_CTRL) begin
               ctrl_q <= ctrl_d;
            end
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= dspmac_pkg::RESP_OKAY;
         rdata_q <= 32'h0;
      end else if (ce) begin
         arready_q <= rdGo;
         if (rdTake) begin
            rvalid_q <= 1'b1;
            rdata_q <= rdValue;
            rresp_q <= regKnown(s_axi_araddr) ? dspmac_pkg::RESP_OKAY
               : dspmac_pkg::RESP_DECERR;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   chk_clear_result: assert property (halfClr[0] |=> result_q[0] == 18'h0)
      else $error("lower result not cleared");
   chk_hold_result: assert property (!halfEn[1] && !halfClr[1] |=>
      $stable(result_q[5]) && $stable(acc_q[1]))
      else $error("upper half changed while disabled");
   chk_simple_normal: assert property (halfEn[0] && !halfClr[0] && !wideSel &&
      funcSel[0] == dspmac_pkg::DSPMAC_SIMPLE && !narrowSel[0]
      |=> {result_q[1], result_q[0]} == $past(pQ[0][35:0]))
      else $error("18-bit product mismatch");
   chk_simple_narrow: assert property (halfEn[1] && !halfClr[1] && !wideSel &&
      funcSel[1] == dspmac_pkg::DSPMAC_SIMPLE && narrowSel[1]
      |=> result_q[6] == $past(pLo[3][17:0]) && result_q[7] == $past(pHi[3][17:0]))
      else $error("9-bit product mismatch");
   chk_wide_product: assert property (halfEn[0] && !halfClr[0] && wideSel |=>
      {result_q[3], result_q[2], result_q[1], result_q[0]} == $past(p72[71:0]))
      else $error("36-bit product mismatch");
   chk_acc_reload: assert property (halfEn[0] && !halfClr[0] && !wideSel &&
      funcSel[0] == dspmac_pkg::DSPMAC_ACCUM && accLoad[0] && addSub[0]
      |=> acc_q[0] == $past(52'(signed'(p18[0]))))
      else $error("accumulator reload mismatch");
   chk_add_pair: assert property (halfEn[0] && !halfClr[0] && !wideSel &&
      funcSel[0] == dspmac_pkg::DSPMAC_ADD2 && !narrowSel[0]
      |=> {result_q[1], result_q[0]} == $past(sum18[0][35:0]))
      else $error("pair sum mismatch");
   chk_pair_clamp: assert property (pairClamp[0] |-> !qOver(pQ[0]) && !qOver(pQ[1]))
      else $error("clamped product out of range");
   chk_chain_shift: assert property (halfEn[0] && !halfClr[0] && opASrcSel[1]
      ##1 halfEn[0] && !halfClr[0] && opASrcSel[1] |=> opA_q[1] == $past(opA_q[0]))
      else $error("shift chain did not advance");
   chk_write_resp: assert property (wrTake && ce |=> bvalid_q ##0 !awready_q)
      else $error("write not answered");

   cov_acc_run: cover property (funcSel[0] == dspmac_pkg::DSPMAC_ACCUM && halfEn[0]
      && !accLoad[0] ##1 halfEn[0] && !accLoad[0]);
   cov_wide: cover property (wideSel && halfEn[0]);
   cov_quad_narrow: cover property (funcSel[1] == dspmac_pkg::DSPMAC_ADD4 && narrowSel[1]
      && halfEn[1]);
   cov_chain: cover property (opASrcSel[0] && halfEn[0] ##1 opASrcSel[1] && halfEn[0]);
endmodule
`default_nettype wire

// ===== dv/dspmac_fabric_rows.sv
`timescale 1ns/10ps
`default_nettype none
// fabric rows beside the block: each row registers what it sends, so inputs move on edges
module dspmac_fabric_rows (
   input wire logic clk_sys,
   input wire logic [17:0] rowA [4],
   input wire logic [17:0] rowB [4],
   input wire logic [3:0] rowEnable,
   input wire logic [3:0] rowClear,
   input wire logic [17:0] upA,
   input wire logic [17:0] upB,
   output logic [17:0] operandA [4],
   output logic [17:0] operandB [4],
   output logic [3:0] clockEnableSet,
   output logic [3:0] asyncClearSet,
   output logic [17:0] chainAIn,
   output logic [17:0] chainBIn
);
   always_ff @(posedge clk_sys) begin
      operandA <= rowA;
      operandB <= rowB;
      clockEnableSet <= rowEnable;
      asyncClearSet <= rowClear;
      chainAIn <= upA;
      chainBIn <= upB;
   end
endmodule
`default_nettype wire

// ===== dv/dspmac_block_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dspmac_block_tb_top;
   logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, signASel = 1'b1, signBSel = 1'b0;
   logic lowerAddOrSubtract = 1'b1, upperAddOrSubtract = 1'b1, lowerAccLoad = 1'b0;
   logic upperAccLoad = 1'b0, lowerPairRndSel = 1'b0, upperPairRndSel = 1'b0;
   logic lowerPairClampSel = 1'b0, upperPairClampSel = 1'b0, lowerSumRndSel = 1'b0;
   logic upperSumRndSel = 1'b0, lowerAccClampSel = 1'b0, upperAccClampSel = 1'b0;
   logic [17:0] rowA [4] = '{default: 18'h0}, rowB [4] = '{default: 18'h0};
   logic [17:0] operandA [4], operandB [4], resultOut [8];
   logic [17:0] upA = 18'h0, upB = 18'h0, chainAIn, chainBIn, chainAOut, chainBOut;
   logic [3:0] rowEnable = 4'hF, rowClear = 4'h0, clockEnableSet, asyncClearSet;
   logic [3:0] opASrcSel = 4'h0, opBSrcSel = 4'h0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [71:0] va, vb, acc, exp0;
   int errors = 0, checksDone = 0;

   always #2.5 clk_sys = ~clk_sys;

   dspmac_fabric_rows rows (.clk_sys, .rowA, .rowB, .rowEnable, .rowClear, .upA, .upB,
      .operandA, .operandB, .clockEnableSet, .asyncClearSet, .chainAIn, .chainBIn);
   dspmac_block uut (.clk_sys, .rst, .ce, .operandA, .operandB, .opASrcSel, .opBSrcSel,
      .chainAIn, .chainBIn, .chainAOut, .chainBOut, .clockEnableSet, .asyncClearSet,
      .signASel, .signBSel, .lowerAddOrSubtract, .upperAddOrSubtract, .lowerPairRndSel,
      .upperPairRndSel, .lowerPairClampSel, .upperPairClampSel, .lowerSumRndSel,
      .upperSumRndSel, .lowerAccClampSel, .upperAccClampSel, .lowerAccLoad, .upperAccLoad,
      .resultOut, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   // ----------------------------------------------------------------
   // bus cycles, expectations and comparison
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [71:0] seen, input logic [71:0] want);
      checksDone++;
      if (seen !== want) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checksDone, errors);
      if (errors == 0 && checksDone > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // entered just after an edge; the closing edge keeps two calls from touching one strobe
   task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
      if (wr) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      do @(posedge clk_sys); while ((wr ? s_axi_awready & s_axi_wready : s_axi_arready) !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic setCtrl(input logic [31:0] d);
      axi(1'b1, dspmac_pkg::ADDR_CTRL, d);
      check("write response", 72'(r), 72'(dspmac_pkg::RESP_OKAY));
   endtask
   // rows are packed row 0 lowest; six edges cover fabric, operand and result registers
   task automatic ops(input logic [71:0] a, input logic [71:0] b);
      for (int i = 0; i < 4; i++) begin
         rowA[i] <= a[18*i+:18];
         rowB[i] <= b[18*i+:18];
      end
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic done(input string t);
      $display("test %s done", t);
   endtask
   function automatic logic [71:0] mulx(input logic [71:0] a, b, input int w, input logic sa, sb);
      logic [71:0] m;
      m = (72'h1 << w) - 72'h1;
      a = (sa && a[w-1]) ? (a | ~m) : (a & m);
      b = (sb && b[w-1]) ? (b | ~m) : (b & m);
      return a * b;
   endfunction
   function automatic logic [71:0] mr(input int i, input int s, input int w);
      return mulx(va >> (18 * i + s), vb >> (18 * i + s), w, signASel, signBSel);
   endfunction
   function automatic logic [71:0] tr(input logic [71:0] x, input int w);
      return x & ((72'h1 << w) - 72'h1);
   endfunction
   function automatic logic [71:0] row(input int i);
      return 72'({resultOut[2*i+1], resultOut[2*i]});
   endfunction
   function automatic logic [71:0] half(input int h);
      return {resultOut[4*h+3], resultOut[4*h+2], resultOut[4*h+1], resultOut[4*h]};
   endfunction

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      axi(1'b0, dspmac_pkg::ADDR_CTRL, 32'h0);
      check("ctrl reset", 72'(q), 72'(dspmac_pkg::CTRL_RESET));
      setCtrl(32'hFFFF_FFFF);
      axi(1'b0, dspmac_pkg::ADDR_CTRL, 32'h0);
      check("ctrl writable bits", 72'(q), 72'(dspmac_pkg::CTRL_MASK));
      axi(1'b0, 4'h8, 32'h0);
      check("unmapped read", 72'(r), 72'(dspmac_pkg::RESP_DECERR));
      setCtrl(dspmac_pkg::CTRL_RESET);
      done("registers");
      va = {18'h3FFFF, 18'h1F00F, 18'h00ABC, 18'h20000};
      vb = {18'h3FFFF, 18'h00007, 18'h12345, 18'h1FFFF};
      ops(va, vb);
      for (int i = 0; i < 4; i++) begin
         check("product 18", row(i), tr(mr(i, 0, 18), 36));
      end
      done("simple 18");
      signBSel <= 1'b1;
      upperAddOrSubtract <= 1'b0;
      upperAccLoad <= 1'b1;
      setCtrl(32'h0000_2014);
      ops(va, vb);
      for (int i = 0; i < 4; i++) begin
         check("product 9", 72'(resultOut[i]), tr(mr(i / 2, 9 * (i % 2), 9), 18));
      end
      upperAccLoad <= 1'b0;
      repeat (4) @(posedge clk_sys);
      acc = half(1);
      @(posedge clk_sys);
      check("accumulate step", half(1) - acc, -mr(2, 0, 18));
      upperAccLoad <= 1'b1;
      upperSumRndSel <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check("rounded accumulator", half(1), (72'h4000 - mr(2, 0, 18)) & ~72'h7FFF);
      upperSumRndSel <= 1'b0;
      done("mixed halves");
      lowerAddOrSubtract <= 1'b0;
      setCtrl(32'h0000_2006);
      ops(va, vb);
      for (int i = 0; i < 2; i++) begin
         check("pair sum", row(i), tr(mr(i, 0, 9) - mr(i, 9, 9), 36));
      end
      done("two-product sum");
      setCtrl(32'h0000_0100);
      ops(va, vb);
      check("wide product", half(0), mr(0, 0, 36));
      check("wide upper idle", half(1), 72'h0);
      done("wide");
      lowerPairClampSel <= 1'b1;
      upperPairClampSel <= 1'b1;
      setCtrl(dspmac_pkg::CTRL_RESET);
      va = {18'h3FF00, 18'h20000, 18'h00123, 18'h20000};
      vb = {18'h00456, 18'h1FFFF, 18'h00456, 18'h20000};
      ops(va, vb);
      check("clamp high", row(0), 72'h0_3FFF_FFFF);
      check("clamp low", row(2), 72'hF_C000_0000);
      axi(1'b0, dspmac_pkg::ADDR_STATUS, 32'h0);
      check("clamp status", 72'(q), 72'h3);
      lowerPairClampSel <= 1'b0;
      upperPairClampSel <= 1'b0;
      lowerPairRndSel <= 1'b1;
      upperPairRndSel <= 1'b1;
      ops(va, vb);
      for (int i = 1; i < 4; i += 2) begin
         check("rounded", row(i), tr((mr(i, 0, 18) + 72'h4000) & ~72'h7FFF, 36));
      end
      done("clamp and round");
      lowerPairRndSel <= 1'b0;
      upperPairRndSel <= 1'b0;
      ops(va, vb);
      exp0 = tr(mr(0, 0, 18), 36);
      rowEnable <= 4'hE;
      va = {va[53:0], va[71:54]};
      ops(va, vb);
      check("held while disabled", row(0), exp0);
      check("other set runs", row(3), tr(mr(3, 0, 18), 36));
      rowClear <= 4'h1;
      ops(va, vb);
      check("cleared", row(1), 72'h0);
      rowClear <= 4'h0;
      rowEnable <= 4'hF;
      done("enable and clear");
      opASrcSel <= 4'hF;
      opBSrcSel <= 4'hF;
      upA <= 18'h2A5C3;
      upB <= 18'h15A3C;
      repeat (10) @(posedge clk_sys);
      check("chain a out", 72'(chainAOut), 72'h2A5C3);
      check("chain b out", 72'(chainBOut), 72'h15A3C);
      exp0 = tr(mulx(72'h2A5C3, 72'h15A3C, 18, 1'b1, 1'b1), 36);
      check("chain product", row(1), exp0);
      done("shift chain");
      opASrcSel <= 4'h0;
      opBSrcSel <= 4'h0;
      lowerAddOrSubtract <= 1'b1;
      lowerAccLoad <= 1'b1;
      setCtrl(32'h0000_2041);
      ops(va, vb);
      check("accumulator load", half(0), mr(0, 0, 18));
      check("upper product 9", 72'(resultOut[7]), tr(mr(3, 9, 9), 18));
      lowerAddOrSubtract <= 1'b0;
      setCtrl(32'h0000_2032);
      ops(va, vb);
      check("pair sum 18", half(0), mr(0, 0, 18) - mr(1, 0, 18));
      check("upper quad idle", half(1), 72'h0);
      setCtrl(32'h0000_2033);
      ops(va, vb);
      exp0 = mr(0, 0, 18) - mr(1, 0, 18) + mr(2, 0, 18) - mr(3, 0, 18);
      check("four-product sum", half(0), exp0);
      setCtrl(32'h0000_2077);
      ops(va, vb);
      exp0 = mr(2, 0, 9) - mr(2, 9, 9) + mr(3, 0, 9) - mr(3, 9, 9);
      check("narrow four sum", half(1), exp0);
      ce <= 1'b0;
      ops(~va, vb);
      check("frozen by enable", half(1), exp0);
      ce <= 1'b1;
      done("sums and freeze");
      complete_run;
   end

   // the tests take some two hundred cycles; a hundred times that means a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      complete_run;
   end
endmodule
`default_nettype wire
